// file: rtl/lfsm_state_map.v
// legacy floating-point control/status registers and register aliasing
`timescale 1ns/100ps
`include "lfsm_consts.vh"

// Function
// RULE1 - legacy control/status kept apart from native status/control
// RULE2 - control 0..5 scalar masks
// RULE3 - control bit 6 reads one; 7, 32..37 read zero
// RULE4 - control 8..9 scalar precision
// RULE5 - control 10..11 scalar rounding
// RULE6 - control bit 12 infinity select stored only
// RULE7 - control 39..44 packed masks
// RULE8 - control 45..46 packed rounding, 47 flush to zero
// RULE9 - status 0..5 flags, 6 stack fault, 7 summary
// RULE10 - status cc 8..10,14; top 11..13; busy mirrors summary
// RULE11 - tags on even bits 16..30; odd and 39..47 read zero
// RULE12 - native reads give empty tags; legacy reads give classes
// RULE13 - status 32..37 packed flags
// RULE14 - native summary read computed from unmasked flags
// RULE15 - native summary write faults next legacy instruction
// RULE16 - packed64 marks tags full; empty-state marks empty
// RULE17 - capture operand and instruction pointers
// RULE18 - packed64 0..7 alias physical 8..15
// RULE19 - packed64 write: sign, exponent ones; data in mantissa
// RULE20 - packed reads return mantissa only
// RULE21 - packed128 pairs physical 16..31, low even, high odd
// RULE22 - packed128 write: exponent 0x1003E, sign zero
// RULE23 - reserved bits read zero, ignore writes
module lfsm_state_map (
    input wire mclk_i,
    input wire rst_n_i,
    // register port
    input wire [1:0] reg_addr_i,
    input wire [63:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire reg_legacy_i,
    output reg [63:0] reg_rdata_o,
    // legacy execution: exceptions and status updates
    input wire exc_set_i,
    input wire [5:0] exc_scalar_i,
    input wire exc_stack_fault_i,
    input wire [5:0] exc_packed_i,
    input wire cc_we_i,
    input wire [3:0] cc_i,
    input wire [2:0] top_i,
    input wire ptr_capture_i,
    input wire [31:0] operand_offset_i,
    input wire [15:0] operand_selector_i,
    input wire [31:0] code_offset_i,
    input wire [15:0] code_selector_i,
    input wire [10:0] opcode_i,
    input wire legacy_fp_instr_i,
    input wire packed64_instr_i,
    input wire empty_state_instr_i,
    output reg numeric_fault_o,
    // legacy controls
    output wire [5:0] scalar_masks_o,
    output wire [1:0] precision_select_o,
    output wire [1:0] rounding_select_o,
    output wire [5:0] packed_masks_o,
    output wire [1:0] packed_rounding_o,
    output wire flush_to_zero_o,
    // physical register writes
    input wire fp_wr_i,
    input wire [4:0] fp_wr_idx_i,
    input wire [81:0] fp_wr_data_i,
    input wire p64_wr_i,
    input wire [2:0] p64_wr_idx_i,
    input wire [63:0] p64_wr_data_i,
    input wire p128_wr_i,
    input wire [2:0] p128_wr_idx_i,
    input wire [127:0] p128_wr_data_i,
    // physical register reads
    input wire rd_en_i,
    input wire [1:0] rd_kind_i,
    input wire [4:0] rd_idx_i,
    output reg rd_valid_o,
    output wire [81:0] rd_fp_o,
    output wire [127:0] rd_vec_o
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    reg [5:0] smask_reg, pmask_reg, sflag_reg, pflag_reg;
    reg [1:0] prec_reg, rnd_reg, prnd_reg, rd_kind_reg;
    reg inf_reg, ftz_reg, sf_reg, es_pend_reg;
    reg [3:0] cc_reg;
    reg [2:0] top_reg;
    reg [7:0] tag_reg;
    reg [63:0] opnd_reg, inst_reg;
    reg [15:0] class_reg;
    wire wr_ctl, wr_sts, summary;
    wire [63:0] ctl_view, sts_view;
    wire [15:0] legacy_tags, tag_spread;

    assign wr_ctl = reg_wr_i && (reg_addr_i == `LFSM_IDX_CONTROL);
    assign wr_sts = reg_wr_i && (reg_addr_i == `LFSM_IDX_STATUS);

    // legacy controls leave only through these ports, never the native unit [RULE1]
    assign scalar_masks_o = smask_reg;
    assign precision_select_o = prec_reg;
    assign rounding_select_o = rnd_reg;
    assign packed_masks_o = pmask_reg;
    assign packed_rounding_o = prnd_reg;
    assign flush_to_zero_o = ftz_reg;

    // --------------------------------------------------------------
    // control register
    // --------------------------------------------------------------
    // software write of the writable fields only
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            smask_reg <= 6'h3F;
            prec_reg <= 2'h3;
            rnd_reg <= 2'h0;
            inf_reg <= 1'b0;
            pmask_reg <= 6'h3F;
            prnd_reg <= 2'h0;
            ftz_reg <= 1'b0;
        end else if (wr_ctl) begin
            smask_reg <= reg_wdata_i[`LFSM_CTL_SMASK_MSB:`LFSM_CTL_SMASK_LSB]; // [RULE2]
            prec_reg <= reg_wdata_i[`LFSM_CTL_PREC_MSB:`LFSM_CTL_PREC_LSB]; // [RULE4]
            rnd_reg <= reg_wdata_i[`LFSM_CTL_RND_MSB:`LFSM_CTL_RND_LSB]; // [RULE5]
            inf_reg <= reg_wdata_i[`LFSM_CTL_INF_BIT]; // [RULE6]
            pmask_reg <= reg_wdata_i[`LFSM_CTL_PMASK_MSB:`LFSM_CTL_PMASK_LSB]; // [RULE7]
            prnd_reg <= reg_wdata_i[`LFSM_CTL_PRND_MSB:`LFSM_CTL_PRND_LSB]; // [RULE8]
            ftz_reg <= reg_wdata_i[`LFSM_CTL_FTZ_BIT]; // [RULE8]
        end
    end

    // read view: bit 6 forced one, ignored and reserved bits zero
    assign ctl_view = {16'h0000, ftz_reg, prnd_reg, pmask_reg, 7'h00, // [RULE3] [RULE23]
                       19'h0_0000, inf_reg, rnd_reg, prec_reg, 1'b0, 1'b1, // [RULE3]
                       smask_reg};

    // --------------------------------------------------------------
    // status register
    // --------------------------------------------------------------
    // summary of unmasked pending scalar exceptions plus stack fault
    assign summary = (|(sflag_reg & ~smask_reg)) | sf_reg; // [RULE14]

    // flags: hardware sets win over a software write in the same cycle
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sflag_reg <= 6'h00;
            sf_reg <= 1'b0;
            pflag_reg <= 6'h00;
        end else begin
            if (wr_sts) begin
                sflag_reg <= reg_wdata_i[`LFSM_STS_SFLAG_MSB:`LFSM_STS_SFLAG_LSB] // [RULE9]
                             | (exc_set_i ? exc_scalar_i : 6'h00);
                sf_reg <= reg_wdata_i[`LFSM_STS_SF_BIT] | (exc_set_i & exc_stack_fault_i);
                pflag_reg <= reg_wdata_i[`LFSM_STS_PFLAG_MSB:`LFSM_STS_PFLAG_LSB] // [RULE13]
                             | (exc_set_i ? exc_packed_i : 6'h00);
            end else if (exc_set_i) begin
                sflag_reg <= sflag_reg | exc_scalar_i; // [RULE9]
                sf_reg <= sf_reg | exc_stack_fault_i;
                pflag_reg <= pflag_reg | exc_packed_i; // [RULE13]
            end
        end
    end

    // condition codes and stack top
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cc_reg <= 4'h0;
            top_reg <= 3'h0;
        end else if (cc_we_i) begin
            cc_reg <= cc_i; // [RULE10]
            top_reg <= top_i;
        end else if (wr_sts) begin
            cc_reg <= {reg_wdata_i[`LFSM_STS_CC3_BIT], reg_wdata_i[`LFSM_STS_CC2_BIT], // [RULE10]
                       reg_wdata_i[`LFSM_STS_CC1_BIT], reg_wdata_i[`LFSM_STS_CC0_BIT]};
            top_reg <= reg_wdata_i[`LFSM_STS_TOP_MSB:`LFSM_STS_TOP_LSB];
        end
    end

    // tags: instruction events take priority over a software write
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_reg <= `LFSM_TAGS_EMPTY;
        end else if (empty_state_instr_i) begin
            tag_reg <= `LFSM_TAGS_EMPTY; // [RULE16]
        end else if (packed64_instr_i || p64_wr_i) begin
            tag_reg <= `LFSM_TAGS_FULL; // [RULE16]
        end else if (wr_sts) begin
            tag_reg <= {reg_wdata_i[30], reg_wdata_i[28], reg_wdata_i[26], // [RULE11]
                        reg_wdata_i[24], reg_wdata_i[22], reg_wdata_i[20],
                        reg_wdata_i[18], reg_wdata_i[16]};
        end
    end

    // delayed exception pending after a native write of the summary bit
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            es_pend_reg <= 1'b0;
            numeric_fault_o <= 1'b0;
        end else begin
            numeric_fault_o <= legacy_fp_instr_i & (es_pend_reg | summary); // [RULE15]
            if (wr_sts && reg_wdata_i[`LFSM_STS_ES_BIT]) begin
                es_pend_reg <= 1'b1; // [RULE15]
            end else if (legacy_fp_instr_i) begin
                es_pend_reg <= 1'b0;
            end
        end
    end

    // per-register tag classes, and their empty override for legacy reads
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_tag
            assign tag_spread[2*gi+1:2*gi] = {1'b0, tag_reg[gi]}; // [RULE11]
            assign legacy_tags[2*gi+1:2*gi] = tag_reg[gi] ? `LFSM_CLASS_EMPTY // [RULE12]
                                                          : class_reg[2*gi+1:2*gi];
        end
    endgenerate

    // status read view; busy mirrors the computed summary
    assign sts_view = {16'h0000, 9'h000, 1'b0, pflag_reg, // [RULE11] [RULE23]
                       (reg_legacy_i ? legacy_tags : tag_spread), // [RULE12]
                       summary, cc_reg[3], top_reg, cc_reg[2:0], // [RULE10]
                       (reg_legacy_i ? es_pend_reg | summary : summary), // [RULE14]
                       sf_reg, sflag_reg};

    // --------------------------------------------------------------
    // pending exception pointers
    // --------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opnd_reg <= 64'h0000_0000_0000_0000;
            inst_reg <= 64'h0000_0000_0000_0000;
        end else if (ptr_capture_i) begin
            opnd_reg <= {16'h0000, operand_selector_i, operand_offset_i}; // [RULE17]
            inst_reg <= {5'h00, opcode_i, code_selector_i, code_offset_i}; // [RULE17]
        end else if (reg_wr_i && (reg_addr_i == `LFSM_IDX_OPERAND)) begin
            opnd_reg <= {16'h0000, reg_wdata_i[`LFSM_SEL_MSB:0]}; // [RULE23]
        end else if (reg_wr_i && (reg_addr_i == `LFSM_IDX_INSTR)) begin
            inst_reg <= {5'h00, reg_wdata_i[`LFSM_OPC_MSB:0]}; // [RULE23]
        end
    end

    // --------------------------------------------------------------
    // register read port, data one cycle after the strobe
    // --------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 64'h0000_0000_0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `LFSM_IDX_CONTROL: reg_rdata_o <= ctl_view;
                `LFSM_IDX_STATUS: reg_rdata_o <= sts_view;
                `LFSM_IDX_OPERAND: reg_rdata_o <= opnd_reg;
                `LFSM_IDX_INSTR: reg_rdata_o <= inst_reg;
                default: reg_rdata_o <= 64'h0000_0000_0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 64'h0000_0000_0000_0000;
        end
    end

    // --------------------------------------------------------------
    // physical register write arbitration
    // --------------------------------------------------------------
    reg wa_en, wb_en;
    reg [4:0] wa_addr, wb_addr;
    reg [81:0] wa_data, wb_data;
    wire fp_in_range;
    wire [4:0] fp_entry, p128_even;

    assign fp_in_range = (fp_wr_idx_i >= `LFSM_FR_BASE);
    assign fp_entry = fp_wr_idx_i - `LFSM_FR_BASE;
    assign p128_even = `LFSM_P128_BASE + {1'b0, p128_wr_idx_i, 1'b0}; // [RULE21]

    // packed128 uses both ports; packed64 on port b, else native on port a
    always @* begin
        wa_en = 1'b0;
        wa_addr = 5'h00;
        wa_data = {`LFSM_FR_W{1'b0}};
        wb_en = 1'b0;
        wb_addr = 5'h00;
        wb_data = {`LFSM_FR_W{1'b0}};
        if (p128_wr_i) begin
            wa_en = 1'b1;
            wa_addr = p128_even; // [RULE21]
            wa_data = {1'b0, `LFSM_P128_EXP, p128_wr_data_i[63:0]}; // [RULE22]
            wb_en = 1'b1;
            wb_addr = p128_even + 5'h01; // [RULE21]
            wb_data = {1'b0, `LFSM_P128_EXP, p128_wr_data_i[127:64]}; // [RULE22]
        end
        if (p64_wr_i && !p128_wr_i) begin
            wb_en = 1'b1;
            wb_addr = {2'b00, p64_wr_idx_i}; // [RULE18]
            wb_data = {1'b1, `LFSM_P64_EXP, p64_wr_data_i}; // [RULE19]
        end
        if (fp_wr_i && fp_in_range && !p128_wr_i && !p64_wr_i) begin
            wa_en = 1'b1;
            wa_addr = fp_entry;
            wa_data = fp_wr_data_i;
        end
    end

    // class of each register 8..15 tracked as it is written
    function [1:0] fr_class;
        input [81:0] v;
        begin
            fr_class = (v[`LFSM_EXP_MSB:`LFSM_EXP_LSB] == `LFSM_P64_EXP) ? `LFSM_CLASS_SPECIAL
                     : (v[63:0] == 64'h0000_0000_0000_0000) ? `LFSM_CLASS_ZERO
                     : v[63] ? `LFSM_CLASS_VALID : `LFSM_CLASS_SPECIAL;
        end
    endfunction

    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_class
            always @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    class_reg[2*gi+1:2*gi] <= `LFSM_CLASS_ZERO;
                end else if (wb_en && (wb_addr == gi)) begin
                    class_reg[2*gi+1:2*gi] <= fr_class(wb_data); // [RULE12]
                end else if (wa_en && (wa_addr == gi)) begin
                    class_reg[2*gi+1:2*gi] <= fr_class(wa_data); // [RULE12]
                end
            end
        end
    endgenerate

    // --------------------------------------------------------------
    // physical register reads
    // --------------------------------------------------------------
    reg [4:0] ra_addr, rb_addr;
    wire [81:0] ra_data, rb_data;

    // address per read kind
    always @* begin
        ra_addr = 5'h00;
        rb_addr = 5'h00;
        case (rd_kind_i)
            `LFSM_RK_FULL: ra_addr = rd_idx_i - `LFSM_FR_BASE;
            `LFSM_RK_P64: ra_addr = {2'b00, rd_idx_i[2:0]}; // [RULE18]
            `LFSM_RK_P128: begin
                ra_addr = `LFSM_P128_BASE + {1'b0, rd_idx_i[2:0], 1'b0}; // [RULE21]
                rb_addr = `LFSM_P128_BASE + {1'b0, rd_idx_i[2:0], 1'b1};
            end
            default: ra_addr = 5'h00;
        endcase
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_valid_o <= 1'b0;
            rd_kind_reg <= `LFSM_RK_FULL;
        end else begin
            rd_valid_o <= rd_en_i;
            rd_kind_reg <= rd_kind_i;
        end
    end

    // packed views carry only mantissas; high half zero for packed64
    assign rd_fp_o = ra_data;
    assign rd_vec_o = {(rd_kind_reg == `LFSM_RK_P128) ? rb_data[63:0] // [RULE20]
                                                      : 64'h0000_0000_0000_0000,
                       ra_data[63:0]}; // [RULE20]

    lfsm_fr_mem u_mem (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .wa_en_i(wa_en),
        .wa_addr_i(wa_addr),
        .wa_data_i(wa_data),
        .wb_en_i(wb_en),
        .wb_addr_i(wb_addr),
        .wb_data_i(wb_data),
        .ra_addr_i(ra_addr),
        .rb_addr_i(rb_addr),
        .ra_data_o(ra_data),
        .rb_data_o(rb_data)
    );

endmodule

// file: rtl/lfsm_consts.vh
// constants for the legacy floating-point state mapping block
`ifndef LFSM_CONSTS_VH
`define LFSM_CONSTS_VH

// --------------------------------------------------------------
// register bus map (register indices)
// --------------------------------------------------------------
`define LFSM_ADDR_W 2
`define LFSM_IDX_CONTROL 2'h0
`define LFSM_IDX_STATUS 2'h1
`define LFSM_IDX_OPERAND 2'h2
`define LFSM_IDX_INSTR 2'h3

// --------------------------------------------------------------
// control register fields
// --------------------------------------------------------------
`define LFSM_CTL_SMASK_LSB 0
`define LFSM_CTL_SMASK_MSB 5
`define LFSM_CTL_ONE_BIT 6
`define LFSM_CTL_PREC_LSB 8
`define LFSM_CTL_PREC_MSB 9
`define LFSM_CTL_RND_LSB 10
`define LFSM_CTL_RND_MSB 11
`define LFSM_CTL_INF_BIT 12
`define LFSM_CTL_PMASK_LSB 39
`define LFSM_CTL_PMASK_MSB 44
`define LFSM_CTL_PRND_LSB 45
`define LFSM_CTL_PRND_MSB 46
`define LFSM_CTL_FTZ_BIT 47
`define LFSM_CTL_RESET 64'h0000_1F80_0000_037F

// --------------------------------------------------------------
// status register fields
// --------------------------------------------------------------
`define LFSM_STS_SFLAG_LSB 0
`define LFSM_STS_SFLAG_MSB 5
`define LFSM_STS_SF_BIT 6
`define LFSM_STS_ES_BIT 7
`define LFSM_STS_CC0_BIT 8
`define LFSM_STS_CC1_BIT 9
`define LFSM_STS_CC2_BIT 10
`define LFSM_STS_TOP_LSB 11
`define LFSM_STS_TOP_MSB 13
`define LFSM_STS_CC3_BIT 14
`define LFSM_STS_BUSY_BIT 15
`define LFSM_STS_TAG_LSB 16
`define LFSM_STS_PFLAG_LSB 32
`define LFSM_STS_PFLAG_MSB 37
`define LFSM_TAGS_EMPTY 8'hFF
`define LFSM_TAGS_FULL 8'h00

// --------------------------------------------------------------
// pointer register fields
// --------------------------------------------------------------
`define LFSM_OFS_MSB 31
`define LFSM_SEL_LSB 32
`define LFSM_SEL_MSB 47
`define LFSM_OPC_LSB 48
`define LFSM_OPC_MSB 58

// --------------------------------------------------------------
// physical register file layout
// --------------------------------------------------------------
`define LFSM_FR_W 82
`define LFSM_FR_ENTRIES 24
`define LFSM_FR_BASE 5'h08
`define LFSM_P128_BASE 5'h08
`define LFSM_EXP_LSB 64
`define LFSM_EXP_MSB 80
`define LFSM_SIGN_BIT 81
`define LFSM_P64_EXP 17'h1_FFFF
`define LFSM_P128_EXP 17'h1_003E
`define LFSM_CLASS_VALID 2'h0
`define LFSM_CLASS_ZERO 2'h1
`define LFSM_CLASS_SPECIAL 2'h2
`define LFSM_CLASS_EMPTY 2'h3

// read kinds on the execution read port
`define LFSM_RK_FULL 2'h0
`define LFSM_RK_P64 2'h1
`define LFSM_RK_P128 2'h2

`endif

// file: rtl/lfsm_fr_mem.v
// physical floating-point register storage, two write and two read ports
`timescale 1ns/100ps
`include "lfsm_consts.vh"

module lfsm_fr_mem (
    input wire mclk_i,
    input wire rst_n_i,
    input wire wa_en_i,
    input wire [4:0] wa_addr_i,
    input wire [81:0] wa_data_i,
    input wire wb_en_i,
    input wire [4:0] wb_addr_i,
    input wire [81:0] wb_data_i,
    input wire [4:0] ra_addr_i,
    input wire [4:0] rb_addr_i,
    output reg [81:0] ra_data_o,
    output reg [81:0] rb_data_o
);

    reg [81:0] mem [0:23];

    // --------------------------------------------------------------
    // storage writes
    // --------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (wa_en_i) begin
            mem[wa_addr_i] <= wa_data_i;
        end
        if (wb_en_i) begin
            mem[wb_addr_i] <= wb_data_i;
        end
    end

    // --------------------------------------------------------------
    // registered reads
    // --------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ra_data_o <= {`LFSM_FR_W{1'b0}};
            rb_data_o <= {`LFSM_FR_W{1'b0}};
        end else begin
            ra_data_o <= mem[ra_addr_i];
            rb_data_o <= mem[rb_addr_i];
        end
    end

endmodule

// file: bench/lfsm_exec_model.sv
// execution-unit model that issues instruction pulses
`timescale 1ns/100ps
module lfsm_exec_model (
    input wire logic mclk_i,
    output logic legacy_o,
    output logic p64_o,
    output logic empty_o
);
    initial {legacy_o, p64_o, empty_o} = 3'b000;
    // one-cycle pulse: 0 legacy fp, 1 packed64, 2 empty-state
    task automatic issue(input int k);
        @(posedge mclk_i);
        legacy_o <= (k == 0);
        p64_o <= (k == 1);
        empty_o <= (k == 2);
        @(posedge mclk_i);
        {legacy_o, p64_o, empty_o} <= 3'b000;
    endtask
endmodule

// file: bench/lfsm_state_map_monitor.sv
// port checker for the state mapping block
`timescale 1ns/100ps
module lfsm_monitor (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] reg_addr_i,
    input wire logic [63:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_legacy_i,
    input wire logic [63:0] reg_rdata_o,
    input wire logic legacy_fp_instr_i,
    input wire logic numeric_fault_o,
    input wire logic [5:0] scalar_masks_o,
    input wire logic [1:0] precision_select_o,
    input wire logic flush_to_zero_o,
    input wire logic rd_en_i,
    input wire logic [1:0] rd_kind_i,
    input wire logic rd_valid_o,
    input wire logic [127:0] rd_vec_o
);
    logic [63:0] wd_q;
    // write data of the previous cycle
    always @(posedge mclk_i) wd_q <= reg_wdata_i;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_sts_rd; reg_rd_i && reg_addr_i == 2'h1 && !reg_legacy_i; endsequence
    sequence s_es_wr; reg_wr_i && reg_addr_i == 2'h1 && reg_wdata_i[7]; endsequence
    chk_rd_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 64'h0000_0000_0000_0000)
        else $error("read data not idle");
    chk_ctl_fixed: assert property (reg_rd_i && reg_addr_i == 2'h0 |=>
        (reg_rdata_o & 64'hFFFF_007F_FFFF_E080) == 64'h0 && reg_rdata_o[6]) else $error("ctl bits");
    chk_busy_mirror: assert property (s_sts_rd |=> reg_rdata_o[15] == reg_rdata_o[7])
        else $error("busy differs");
    chk_sts_zeros: assert property (s_sts_rd |=>
        (reg_rdata_o & 64'hFFFF_FFC0_AAAA_0000) == 64'h0) else $error("status zero bits");
    chk_es_summary: assert property (s_sts_rd |=> reg_rdata_o[7] ==
        (|(reg_rdata_o[5:0] & ~scalar_masks_o) | reg_rdata_o[6])) else $error("summary wrong");
    chk_mask_load: assert property (reg_wr_i && reg_addr_i == 2'h0 |=>
        scalar_masks_o == wd_q[5:0] && precision_select_o == wd_q[9:8]
        && flush_to_zero_o == wd_q[47]) else $error("control fields");
    chk_fault_quiet: assert property (!legacy_fp_instr_i |=> !numeric_fault_o)
        else $error("stray fault");
    chk_es_fault: assert property (s_es_wr ##2 legacy_fp_instr_i |=> numeric_fault_o)
        else $error("fault missing");
    chk_rd_valid: assert property (1'b1 |=> rd_valid_o == $past(rd_en_i)) else $error("valid");
    chk_p64_high: assert property (rd_en_i && rd_kind_i == 2'h1 |=>
        rd_vec_o[127:64] == 64'h0) else $error("packed64 high half");
endmodule
bind lfsm_state_map lfsm_monitor MON (.*);

// file: bench/tb_top.sv
// self-checking bench for the state mapping block
`timescale 1ns/100ps
module tb_top;
    logic mclk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_legacy_i, rd_valid_o, numeric_fault_o;
    logic exc_set_i, exc_stack_fault_i, cc_we_i, ptr_capture_i, fp_wr_i, p64_wr_i;
    logic p128_wr_i, rd_en_i, flush_to_zero_o;
    logic legacy_fp_instr_i, packed64_instr_i, empty_state_instr_i;
    logic [1:0] reg_addr_i, rd_kind_i, precision_select_o, rounding_select_o, packed_rounding_o;
    logic [2:0] top_i, p64_wr_idx_i, p128_wr_idx_i;
    logic [3:0] cc_i;
    logic [4:0] fp_wr_idx_i, rd_idx_i;
    logic [5:0] exc_scalar_i, exc_packed_i, scalar_masks_o, packed_masks_o;
    logic [10:0] opcode_i;
    logic [15:0] operand_selector_i, code_selector_i;
    logic [31:0] operand_offset_i, code_offset_i;
    logic [63:0] reg_wdata_i, reg_rdata_o, p64_wr_data_i, q;
    logic [81:0] fp_wr_data_i, rd_fp_o;
    logic [127:0] p128_wr_data_i, rd_vec_o;
    logic [129:0] rows [7];
    int miscompares = 0;
    int n_checks = 0;
    lfsm_state_map DUT (.*);
    lfsm_exec_model EXU (.mclk_i(mclk_i), .legacy_o(legacy_fp_instr_i),
        .p64_o(packed64_instr_i), .empty_o(empty_state_instr_i));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [63:0] d);
        @(posedge mclk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge mclk_i);
        {reg_addr_i, reg_rd_i} <= {a, 1'b1};
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 q = reg_rdata_o;
    endtask
    task automatic rf(input logic [1:0] k, input logic [4:0] i);
        @(posedge mclk_i);
        {rd_en_i, rd_kind_i, rd_idx_i} <= {1'b1, k, i};
        @(posedge mclk_i);
        rd_en_i <= 1'b0;
        #1;
    endtask
    task automatic finish_test;
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {reg_wr_i, reg_rd_i, reg_legacy_i, exc_set_i, exc_stack_fault_i, cc_we_i, ptr_capture_i,
            fp_wr_i, p64_wr_i, p128_wr_i, rd_en_i, reg_addr_i, rd_kind_i, top_i, p64_wr_idx_i,
            p128_wr_idx_i, cc_i, fp_wr_idx_i, rd_idx_i, exc_scalar_i, exc_packed_i, opcode_i,
            operand_selector_i, code_selector_i, operand_offset_i, code_offset_i, reg_wdata_i,
            p64_wr_data_i, fp_wr_data_i, p128_wr_data_i} = '0;
        rows[0] = {2'h0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_FF80_0000_1F7F};
        rows[1] = {2'h0, 64'h0000_0000_0000_0000, 64'h0000_0000_0000_0040};
        rows[2] = {2'h2, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_FFFF_FFFF_FFFF};
        rows[3] = {2'h3, 64'hFFFF_FFFF_FFFF_FFFF, 64'h07FF_FFFF_FFFF_FFFF};
        rows[4] = {2'h1, 64'h0000_0000_0000_0000, 64'h0000_0000_0000_0000};
        rows[5] = {2'h1, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_8081};
        rows[6] = {2'h1, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0000_003F_5555_FFFF};
        rst_n_i = 1'b0;
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(2'h0);
        chk(q, 64'h0000_1F80_0000_037F);
        rd(2'h1);
        chk(q, 64'h0000_0000_5555_0000);
        foreach (rows[r]) begin
            wr(rows[r][129:128], rows[r][127:64]);
            rd(rows[r][129:128]);
            chk(q, rows[r][63:0]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(2'h0, (64'(k) << 45) | (64'(k) << 10) | (64'(k) << 8));
            #1 chk(rounding_select_o, k[1:0]);
            chk(packed_rounding_o, k[1:0]);
            chk(precision_select_o, k[1:0]);
        end
        EXU.issue(0);
        #1 chk(numeric_fault_o, 1'b1);
        wr(2'h1, 64'h0000_0000_0000_0000);
        EXU.issue(0);
        #1 chk(numeric_fault_o, 1'b0);
        @(posedge mclk_i);
        {exc_set_i, cc_we_i, exc_scalar_i, exc_packed_i, cc_i, top_i} <= {2'b11, 6'h02, 6'h01,
            4'h9, 3'h5};
        @(posedge mclk_i);
        {exc_set_i, cc_we_i} <= 2'b00;
        rd(2'h1);
        chk(q, 64'h0000_0001_0000_E982);
        wr(2'h1, 64'h0000_0000_0000_0080);
        EXU.issue(0);
        #1 chk(numeric_fault_o, 1'b1);
        rd(2'h1);
        chk(q, 64'h0000_0000_0000_0000);
        EXU.issue(2);
        rd(2'h1);
        chk(q[31:16], 16'h5555);
        EXU.issue(1);
        rd(2'h1);
        chk(q[31:16], 16'h0000);
        @(posedge mclk_i);
        {p64_wr_i, p64_wr_idx_i, p64_wr_data_i} <= {1'b1, 3'h2, 64'h0123_4567_89AB_CDEF};
        @(posedge mclk_i);
        p64_wr_i <= 1'b0;
        {p128_wr_i, p128_wr_idx_i} <= {1'b1, 3'h3};
        p128_wr_data_i <= 128'hFEDC_BA98_7654_3210_0F1E_2D3C_4B5A_6978;
        @(posedge mclk_i);
        p128_wr_i <= 1'b0;
        rf(2'h0, 5'h0A);
        chk(rd_fp_o, {1'b1, 17'h1_FFFF, 64'h0123_4567_89AB_CDEF});
        rf(2'h1, 5'h02);
        chk(rd_vec_o, {64'h0, 64'h0123_4567_89AB_CDEF});
        rf(2'h0, 5'h17);
        chk(rd_fp_o, {1'b0, 17'h1_003E, 64'hFEDC_BA98_7654_3210});
        rf(2'h2, 5'h03);
        chk(rd_vec_o, 128'hFEDC_BA98_7654_3210_0F1E_2D3C_4B5A_6978);
        reg_legacy_i <= 1'b1;
        rd(2'h1);
        chk(q[31:16], 16'h5565);
        {reg_legacy_i, ptr_capture_i, operand_selector_i} <= {2'b01, 16'h1234};
        @(posedge mclk_i);
        ptr_capture_i <= 1'b0;
        rd(2'h2);
        chk(q, 64'h0000_1234_0000_0000);
        finish_test;
    end
    // watchdog against a hang
    initial begin
        #100000;
        miscompares++;
        finish_test;
    end
endmodule
